// >>> fpg_pkg.sv
// Package with register map, field layout, reset values and timing counts of the frame pulse generator
package fpg_pkg;

  // System clock rate
  localparam int CLOCK_HZ  = 10_000_000;
  localparam int CLOCK_KHZ = CLOCK_HZ / 1000;

  // Register offsets (byte-wide registers)
  localparam logic [7:0] ADDR_RUN    = 8'h51;
  localparam logic [7:0] ADDR_RATE   = 8'h56;
  localparam logic [7:0] ADDR_SHAPE  = 8'h57;
  localparam logic [7:0] ADDR_OFF_LO = 8'h58;
  localparam logic [7:0] ADDR_OFF_MD = 8'h59;
  localparam logic [7:0] ADDR_OFF_HI = 8'h5a;

  // Reset values
  localparam logic [7:0] RST_RUN    = 8'h04;
  localparam logic [7:0] RST_RATE   = 8'h05;
  localparam logic [7:0] RST_SHAPE  = 8'h23;
  localparam logic [7:0] RST_OFF_LO = 8'h00;
  localparam logic [7:0] RST_OFF_MD = 8'h00;
  localparam logic [7:0] RST_OFF_HI = 8'h00;

  // Implemented bits per register; reserved bits read as zero
  localparam logic [7:0] MASK_RUN    = 8'h04;
  localparam logic [7:0] MASK_RATE   = 8'h07;
  localparam logic [7:0] MASK_SHAPE  = 8'hf3;
  localparam logic [7:0] MASK_OFF_HI = 8'h3f;

  // Field positions
  localparam int RUN_BIT    = 2;
  localparam int RATE_LSB   = 0;
  localparam int STYLE_BIT  = 0;
  localparam int EDGE_BIT   = 1;
  localparam int WIDTH_LSB  = 4;
  localparam int POL_BIT    = 7;
  localparam int COARSE_LSB = 0;

  // Width code that means one cycle of output clock 0
  localparam logic [2:0] WIDTH_CODE_CLK0 = 3'h7;

  // Repetition rates in centihertz, codes 000 to 111
  localparam int RATE_CHZ_0 = 16667;
  localparam int RATE_CHZ_1 = 40000;
  localparam int RATE_CHZ_2 = 100000;
  localparam int RATE_CHZ_3 = 200000;
  localparam int RATE_CHZ_4 = 400000;
  localparam int RATE_CHZ_5 = 800000;
  localparam int RATE_CHZ_6 = 3200000;
  localparam int RATE_CHZ_7 = 6400000;

  // Periods in clock cycles
  localparam int PERIOD_CYC_0 = CLOCK_HZ * 100 / RATE_CHZ_0;
  localparam int PERIOD_CYC_1 = CLOCK_HZ * 100 / RATE_CHZ_1;
  localparam int PERIOD_CYC_2 = CLOCK_HZ * 100 / RATE_CHZ_2;
  localparam int PERIOD_CYC_3 = CLOCK_HZ * 100 / RATE_CHZ_3;
  localparam int PERIOD_CYC_4 = CLOCK_HZ * 100 / RATE_CHZ_4;
  localparam int PERIOD_CYC_5 = CLOCK_HZ * 100 / RATE_CHZ_5;
  localparam int PERIOD_CYC_6 = CLOCK_HZ * 100 / RATE_CHZ_6;
  localparam int PERIOD_CYC_7 = CLOCK_HZ * 100 / RATE_CHZ_7;

  // Pulse widths as frequencies in kHz, codes 000 to 101
  localparam int WIDTH_KHZ_0 = 19440;
  localparam int WIDTH_KHZ_1 = 38880;
  localparam int WIDTH_KHZ_2 = 77760;
  localparam int WIDTH_KHZ_3 = 155520;
  localparam int WIDTH_KHZ_4 = 6480;
  localparam int WIDTH_KHZ_5 = 51840;

  // Width in cycles: rounded down, never under one cycle
  localparam int WIDTH_CYC_0 = (CLOCK_KHZ / WIDTH_KHZ_0 < 1) ? 1 : CLOCK_KHZ / WIDTH_KHZ_0;
  localparam int WIDTH_CYC_1 = (CLOCK_KHZ / WIDTH_KHZ_1 < 1) ? 1 : CLOCK_KHZ / WIDTH_KHZ_1;
  localparam int WIDTH_CYC_2 = (CLOCK_KHZ / WIDTH_KHZ_2 < 1) ? 1 : CLOCK_KHZ / WIDTH_KHZ_2;
  localparam int WIDTH_CYC_3 = (CLOCK_KHZ / WIDTH_KHZ_3 < 1) ? 1 : CLOCK_KHZ / WIDTH_KHZ_3;
  localparam int WIDTH_CYC_4 = (CLOCK_KHZ / WIDTH_KHZ_4 < 1) ? 1 : CLOCK_KHZ / WIDTH_KHZ_4;
  localparam int WIDTH_CYC_5 = (CLOCK_KHZ / WIDTH_KHZ_5 < 1) ? 1 : CLOCK_KHZ / WIDTH_KHZ_5;

  // Fine offset step rates in kHz for the two clock families
  localparam int STEP_KHZ_648  = 207360;
  localparam int STEP_KHZ_1944 = 311040;

  // Coarse offset unit: one 8 kHz cycle
  localparam int COARSE_HZ  = 8000;
  localparam int COARSE_CYC = CLOCK_HZ / COARSE_HZ;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpg_bus_t;

  // Decoded configuration handed to the generator
  typedef struct packed {
    logic        run;
    logic [2:0]  rate;
    logic        style;
    logic        sync_falling;
    logic [2:0]  width;
    logic        polarity;
    logic [21:0] offset;
  } fpg_cfg_t;

endpackage

// >>> fpg_regs.sv
// Register file of the frame pulse generator with registered read data
`timescale 1ns/1ns

module fpg_regs
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire fpg_pkg::fpg_bus_t bus,
  output logic [7:0]             rdata,
  output fpg_pkg::fpg_cfg_t      cfg
);

  logic [7:0] run_ctrl;                 // Run enable holder
  logic [7:0] frame_pulse0_rate;        // Repetition rate
  logic [7:0] frame_pulse0_shape;       // Style, edge, width, polarity
  logic [7:0] frame_pulse0_offset_low;  // Offset bits 7:0
  logic [7:0] frame_pulse0_offset_mid;  // Offset bits 15:8
  logic [7:0] frame_pulse0_offset_high; // Offset bits 21:16
  logic [7:0] next_rdata;               // Read mux output

  // Write enables from address decode
  wire we_run   = bus.wr && (bus.addr == fpg_pkg::ADDR_RUN);
  wire we_rate  = bus.wr && (bus.addr == fpg_pkg::ADDR_RATE);
  wire we_shape = bus.wr && (bus.addr == fpg_pkg::ADDR_SHAPE);
  wire we_lo    = bus.wr && (bus.addr == fpg_pkg::ADDR_OFF_LO);
  wire we_md    = bus.wr && (bus.addr == fpg_pkg::ADDR_OFF_MD);
  wire we_hi    = bus.wr && (bus.addr == fpg_pkg::ADDR_OFF_HI);

  // Register storage; reserved bits are masked off so they always read zero
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      run_ctrl                 <= fpg_pkg::RST_RUN;
      frame_pulse0_rate        <= fpg_pkg::RST_RATE;
      frame_pulse0_shape       <= fpg_pkg::RST_SHAPE;
      frame_pulse0_offset_low  <= fpg_pkg::RST_OFF_LO;
      frame_pulse0_offset_mid  <= fpg_pkg::RST_OFF_MD;
      frame_pulse0_offset_high <= fpg_pkg::RST_OFF_HI;
    end
    else
    begin
      if (we_run)   run_ctrl                 <= bus.wdata & fpg_pkg::MASK_RUN;
      if (we_rate)  frame_pulse0_rate        <= bus.wdata & fpg_pkg::MASK_RATE;
      if (we_shape) frame_pulse0_shape       <= bus.wdata & fpg_pkg::MASK_SHAPE;
      if (we_lo)    frame_pulse0_offset_low  <= bus.wdata;
      if (we_md)    frame_pulse0_offset_mid  <= bus.wdata;
      if (we_hi)    frame_pulse0_offset_high <= bus.wdata & fpg_pkg::MASK_OFF_HI;
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb
  begin
    case (bus.addr)
      fpg_pkg::ADDR_RUN:    next_rdata = run_ctrl;
      fpg_pkg::ADDR_RATE:   next_rdata = frame_pulse0_rate;
      fpg_pkg::ADDR_SHAPE:  next_rdata = frame_pulse0_shape;
      fpg_pkg::ADDR_OFF_LO: next_rdata = frame_pulse0_offset_low;
      fpg_pkg::ADDR_OFF_MD: next_rdata = frame_pulse0_offset_mid;
      fpg_pkg::ADDR_OFF_HI: next_rdata = frame_pulse0_offset_high;
      default:              next_rdata = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata <= 8'h00;
    else
      rdata <= bus.rd ? next_rdata : 8'h00;
  end

  // Field decode into the configuration carrier
  assign cfg.run          = run_ctrl[fpg_pkg::RUN_BIT];
  assign cfg.rate         = frame_pulse0_rate[fpg_pkg::RATE_LSB +: 3];
  assign cfg.style        = frame_pulse0_shape[fpg_pkg::STYLE_BIT];
  assign cfg.sync_falling = frame_pulse0_shape[fpg_pkg::EDGE_BIT];
  assign cfg.width        = frame_pulse0_shape[fpg_pkg::WIDTH_LSB +: 3];
  assign cfg.polarity     = frame_pulse0_shape[fpg_pkg::POL_BIT];
  assign cfg.offset       = {frame_pulse0_offset_high[fpg_pkg::COARSE_LSB +: 6],
                             frame_pulse0_offset_mid, frame_pulse0_offset_low};

endmodule

// >>> fpg_top.sv
// Frame pulse generator for frame pulse output 0, with its register port
`timescale 1ns/1ns

module fpg_top
#(
  parameter int PERIOD_CYC_0 = fpg_pkg::PERIOD_CYC_0, // 166.67 Hz period
  parameter int PERIOD_CYC_1 = fpg_pkg::PERIOD_CYC_1, // 400 Hz period
  parameter int PERIOD_CYC_2 = fpg_pkg::PERIOD_CYC_2, // 1 kHz period
  parameter int PERIOD_CYC_3 = fpg_pkg::PERIOD_CYC_3  // 2 kHz period
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       synth_clock_out0,
  input  wire logic       clock0_sonet_family,
  output logic            frame_pulse_out0
);

  // Pulse sequencer states
  typedef enum logic [1:0] {
    FPG_IDLE,
    FPG_ARM,
    FPG_HIGH
  } fpg_state_t;

  fpg_pkg::fpg_bus_t bus;        // Bundled register request
  fpg_pkg::fpg_cfg_t cfg;        // Decoded configuration
  fpg_state_t        state;      // Pulse sequencer state
  fpg_state_t        next_state; // Its next value
  logic [16:0]       phase;      // Position within the frame period
  logic              clk_lvl;    // Clock-style level
  logic              clk0_q;     // Output clock 0 one cycle ago
  logic [3:0]        wcnt;       // Remaining pulse width cycles
  logic [3:0]        next_wcnt;  // Its next value
  logic              next_out;   // Next output level

  // Period in cycles for a rate code; slow rates come from parameters
  function automatic logic [16:0] period_cycles(input logic [2:0] rate);
    case (rate)
      3'h0:    period_cycles = 17'(PERIOD_CYC_0);
      3'h1:    period_cycles = 17'(PERIOD_CYC_1);
      3'h2:    period_cycles = 17'(PERIOD_CYC_2);
      3'h3:    period_cycles = 17'(PERIOD_CYC_3);
      3'h4:    period_cycles = 17'(fpg_pkg::PERIOD_CYC_4);
      3'h5:    period_cycles = 17'(fpg_pkg::PERIOD_CYC_5);
      3'h6:    period_cycles = 17'(fpg_pkg::PERIOD_CYC_6);
      default: period_cycles = 17'(fpg_pkg::PERIOD_CYC_7);
    endcase
  endfunction

  // Pulse width in cycles for a width code
  function automatic logic [3:0] width_cycles(input logic [2:0] code);
    case (code)
      3'h0:    width_cycles = 4'(fpg_pkg::WIDTH_CYC_0);
      3'h1:    width_cycles = 4'(fpg_pkg::WIDTH_CYC_1);
      3'h2:    width_cycles = 4'(fpg_pkg::WIDTH_CYC_2);
      3'h3:    width_cycles = 4'(fpg_pkg::WIDTH_CYC_3);
      3'h4:    width_cycles = 4'(fpg_pkg::WIDTH_CYC_4);
      3'h5:    width_cycles = 4'(fpg_pkg::WIDTH_CYC_5);
      // Code 110 has no defined width; the shortest pulse is the safe fallback
      default: width_cycles = 4'h1;
    endcase
  endfunction

  // Fine offset in whole clock cycles, rounded down; step depends on clock family
  function automatic logic [16:0] fine_cycles(input logic [15:0] fine, input logic fam1944);
    logic [31:0] prod;
    prod = 32'(fine) * 32'(fpg_pkg::CLOCK_KHZ);
    if (fam1944)
      fine_cycles = 17'(prod / 32'(fpg_pkg::STEP_KHZ_1944));
    else
      fine_cycles = 17'(prod / 32'(fpg_pkg::STEP_KHZ_648));
  endfunction

  // Reduce a cycle count into one frame period
  function automatic logic [16:0] wrap(input logic [17:0] value, input logic [16:0] per);
    wrap = 17'(value % 18'(per));
  endfunction

  // Register request bundle
  assign bus.wr    = reg_wr;
  assign bus.rd    = reg_rd;
  assign bus.addr  = reg_addr;
  assign bus.wdata = reg_wdata;

  // Register file; its read data already come from a flip-flop
  fpg_regs fpg_regs_inst
  (
    .clock (clock),
    .rst   (rst),
    .bus   (bus),
    .rdata (reg_rdata),
    .cfg   (cfg)
  );

  // Frame period and total offset in cycles
  wire [16:0] period    = period_cycles(cfg.rate);
  wire [16:0] half      = period >> 1;
  wire [16:0] fine_cyc  = fine_cycles(cfg.offset[15:0], clock0_sonet_family);
  wire [17:0] coarse_cy = 18'(cfg.offset[21:16]) * 18'(fpg_pkg::COARSE_CYC);
  wire [17:0] off_total = coarse_cy + 18'(fine_cyc);
  wire [16:0] offs_mod  = wrap(off_total, period);
  wire [16:0] mid_mod   = wrap(18'(offs_mod) + 18'(half), period);

  // Frame event: the phase counter reaches the programmed offset
  wire frame_event = (phase == offs_mod);
  wire mid_hit     = (phase == mid_mod);
  wire phase_last  = (phase >= period - 17'h1);

  // Edges of output clock 0; the input is already synchronous to clock
  wire clk0_rise = synth_clock_out0 && !clk0_q;
  wire clk0_fall = !synth_clock_out0 && clk0_q;
  wire sync_hit  = cfg.sync_falling ? clk0_fall : clk0_rise;
  wire width_clk0 = (cfg.width == fpg_pkg::WIDTH_CODE_CLK0);

  // Level before polarity: pulse state or clock-style level
  wire active = cfg.style ? (state == FPG_HIGH) : clk_lvl;

  // Phase counter; wraps early if the rate is shortened while running
  always_ff @(posedge clock)
  begin
    if (rst || !cfg.run)
      phase <= 17'h0;
    else if (phase_last)
      phase <= 17'h0;
    else
      phase <= phase + 17'h1;
  end

  // Clock-style level: high for half a period from each frame event
  always_ff @(posedge clock)
  begin
    if (rst || !cfg.run)
      clk_lvl <= 1'b0;
    else if (frame_event)
      clk_lvl <= 1'b1;
    else if (mid_hit)
      clk_lvl <= 1'b0;
  end

  // Delayed copy of output clock 0 for edge detection
  always_ff @(posedge clock)
  begin
    if (rst)
      clk0_q <= 1'b0;
    else
      clk0_q <= synth_clock_out0;
  end

  // Pulse sequencer: wait for event, wait for sync edge, hold for the width
  always_comb
  begin
    next_state = state;
    next_wcnt  = wcnt;
    case (state)
      FPG_IDLE:
      begin
        if (frame_event)
          next_state = FPG_ARM;
      end
      FPG_ARM:
      begin
        // The pulse always starts on the chosen edge of output clock 0
        if (sync_hit)
        begin
          next_state = FPG_HIGH;
          next_wcnt  = width_cycles(cfg.width) - 4'h1;
        end
      end
      FPG_HIGH:
      begin
        if (width_clk0)
        begin
          // One full cycle of output clock 0 ends at the next same edge
          if (sync_hit)
            next_state = FPG_IDLE;
        end
        else if (wcnt == 4'h0)
          next_state = FPG_IDLE;
        else
          next_wcnt = wcnt - 4'h1;
      end
      default:
      begin
        next_state = FPG_IDLE;
      end
    endcase
    // Clock style or a stopped output leaves the sequencer idle
    if (!cfg.run || !cfg.style)
      next_state = FPG_IDLE;
  end

  // Sequencer registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= FPG_IDLE;
      wcnt  <= 4'h0;
    end
    else
    begin
      state <= next_state;
      wcnt  <= next_wcnt;
    end
  end

  // Output level: polarity applied, forced low while stopped
  assign next_out = cfg.run && (active ^ cfg.polarity);

  // Output flip-flop; low during reset
  always_ff @(posedge clock)
  begin
    if (rst)
      frame_pulse_out0 <= 1'b0;
    else
      frame_pulse_out0 <= next_out;
  end

  // Helper logic for the checks below: cycles since the last event and a
  // flag that the rate or the event position has moved since then, so a
  // reprogramming while running is not flagged
  logic [16:0] gap;
  logic [16:0] hi_cnt;
  logic        seen_event;
  logic        rate_moved;
  logic [2:0]  rate_q;
  logic [16:0] offs_q;

  // Track event spacing, clock-style high time and rate changes
  always_ff @(posedge clock)
  begin
    if (rst || !cfg.run)
    begin
      gap        <= 17'h0;
      hi_cnt     <= 17'h0;
      seen_event <= 1'b0;
      rate_moved <= 1'b0;
      rate_q     <= cfg.rate;
      offs_q     <= offs_mod;
    end
    else
    begin
      rate_q <= cfg.rate;
      offs_q <= offs_mod;
      gap    <= frame_event ? 17'h0 : gap + 17'h1;
      hi_cnt <= clk_lvl ? hi_cnt + 17'h1 : 17'h0;
      if (frame_event)
        seen_event <= 1'b1;
      if (frame_event)
        rate_moved <= 1'b0;
      else if (rate_q != cfg.rate || offs_q != offs_mod)
        rate_moved <= 1'b1;
    end
  end

  // Start of a narrow pulse of fixed width
  sequence s_fixed_start;
    state == FPG_ARM && sync_hit && !width_clk0 && cfg.run && cfg.style;
  endsequence

  // Narrow pulse while running, polarity steady into the next cycle
  sequence s_pulse_on;
    state == FPG_HIGH && cfg.run && cfg.style ##1 $stable(cfg.polarity);
  endsequence

  // Stopped output is low on the following cycle
  AST_RUN_LOW: assert property (@(posedge clock) disable iff (rst)
    !cfg.run |=> !frame_pulse_out0)
    else $error("frame pulse output not low while stopped");

  // Events repeat once per selected period when the rate is steady
  AST_RATE_PERIOD: assert property (@(posedge clock) disable iff (rst)
    frame_event && seen_event && !rate_moved && gap != 17'h0 && cfg.run |-> gap == period - 17'h1)
    else $error("frame events not spaced by one period");

  // Clock-style level rises at the event and drives the output
  AST_CLOCK_RISE: assert property (@(posedge clock) disable iff (rst)
    cfg.run && !cfg.style && frame_event ##1 cfg.run && !cfg.style && $stable(cfg.polarity)
      |-> ##1 frame_pulse_out0 == !$past(cfg.polarity))
    else $error("clock-style output did not rise at the event");

  // Clock-style high time is half a period
  AST_CLOCK_DUTY: assert property (@(posedge clock) disable iff (rst)
    cfg.run && clk_lvl && mid_hit && !frame_event && !rate_moved && seen_event |-> hi_cnt == half - 17'h1)
    else $error("clock-style duty cycle not one half");

  // An event in pulse style arms the sequencer
  AST_EVENT_ARMS: assert property (@(posedge clock) disable iff (rst)
    cfg.run && cfg.style && state == FPG_IDLE && frame_event |=> state == FPG_ARM || !cfg.run || !cfg.style)
    else $error("frame event did not arm the pulse");

  // The pulse waits for the chosen edge of output clock 0
  AST_SYNC_EDGE: assert property (@(posedge clock) disable iff (rst)
    state == FPG_ARM && !sync_hit |=> state != FPG_HIGH)
    else $error("pulse started without the selected sync edge");

  // Fixed widths last exactly one cycle at this clock rate
  AST_FIXED_WIDTH: assert property (@(posedge clock) disable iff (rst)
    s_fixed_start ##1 !width_clk0 |-> state == FPG_HIGH ##1 state == FPG_IDLE)
    else $error("fixed pulse width not one cycle");

  // Width code 111 holds the pulse until the next sync edge
  AST_CLK0_WIDTH: assert property (@(posedge clock) disable iff (rst)
    state == FPG_HIGH && width_clk0 && !sync_hit && cfg.run && cfg.style && $stable(cfg.width)
      |=> state == FPG_HIGH)
    else $error("clock0-wide pulse ended before the next edge");

  // The pulse level follows the polarity bit
  AST_POLARITY: assert property (@(posedge clock) disable iff (rst)
    s_pulse_on |-> frame_pulse_out0 == !cfg.polarity)
    else $error("pulse level does not follow polarity");

  // Idle level in pulse style is the inverse of the active level
  AST_IDLE_LEVEL: assert property (@(posedge clock) disable iff (rst)
    cfg.run && cfg.style && state != FPG_HIGH ##1 cfg.run && $stable(cfg.polarity) && $stable(cfg.style)
      |-> frame_pulse_out0 == cfg.polarity)
    else $error("idle level wrong for the selected polarity");

  // The event position lies inside the period, and a zero offset puts it at the start
  AST_OFFSET: assert property (@(posedge clock) disable iff (rst)
    cfg.run |-> offs_mod < period && (cfg.offset != 22'h0 || offs_mod == 17'h0))
    else $error("frame event not at the programmed offset");

  // Reading the rate register returns its stored value in the next cycle
  AST_READ_RATE: assert property (@(posedge clock) disable iff (rst)
    reg_rd && reg_addr == fpg_pkg::ADDR_RATE && !reg_wr |=> reg_rdata == {5'h00, cfg.rate})
    else $error("rate register read back wrong");

endmodule

// >>> fpg_top_bench.sv
// Self-checking bench for the frame pulse generator
`timescale 1ns/1ns

module fpg_top_bench;
  logic       clock       = 1'b0;  // 10 MHz system clock
  logic       rst         = 1'b1;  // Synchronous reset
  logic [7:0] reg_addr    = 8'h00; // Register address
  logic [7:0] reg_wdata   = 8'h00; // Write data
  logic       reg_wr      = 1'b0;  // Write strobe
  logic       reg_rd      = 1'b0;  // Read strobe
  logic [7:0] reg_rdata;           // Read data
  logic       synth       = 1'b0;  // Output clock 0 level
  logic       sonet       = 1'b0;  // Clock family select
  logic       fp_out;              // Frame pulse output
  logic [2:0] sc_cnt      = 3'h0;  // Divider for output clock 0
  int         error_cnt   = 0;     // Mismatches
  int         check_count = 0;     // Comparisons made
  int         base;                // Delay with zero offset
  int         d;                   // Measured delay or width
  int         h;                   // High time
  int         l;                   // Low time
  logic [7:0] rv;                  // Read value
  // Periods per rate code; codes 0 to 3 are shortened below
  int per [8] = '{600, 250, 100, 50, fpg_pkg::PERIOD_CYC_4, fpg_pkg::PERIOD_CYC_5,
                  fpg_pkg::PERIOD_CYC_6, fpg_pkg::PERIOD_CYC_7};
  logic [7:0] ta [6] = '{8'h56, 8'h57, 8'h5a, 8'h58, 8'h59, 8'h50}; // Addresses
  logic [7:0] tw [6] = '{8'h07, 8'hf3, 8'h3f, 8'ha5, 8'h5a, 8'hff}; // Written, reserved bits at default
  logic [7:0] te [6] = '{8'h07, 8'hf3, 8'h3f, 8'ha5, 8'h5a, 8'h00}; // Read back

  // Clock generator
  always #50 clock = ~clock;

  // Output clock 0 toggles every 8 cycles, so a pulse start lands well inside a half period
  always @(posedge clock)
  begin
    sc_cnt <= sc_cnt + 3'h1;
    if (sc_cnt == 3'h7)
      synth <= ~synth;
  end

  fpg_top #(.PERIOD_CYC_0(600), .PERIOD_CYC_1(250), .PERIOD_CYC_2(100), .PERIOD_CYC_3(50)) fpg_top_inst
  (
    .clock               (clock),
    .rst                 (rst),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .synth_clock_out0    (synth),
    .clock0_sonet_family (sonet),
    .frame_pulse_out0    (fp_out)
  );

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask

  // One cycle, then sample once outputs settled
  task automatic cyc();
    @(posedge clock);
    #1;
  endtask

  // Single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Single-cycle read; data stands only in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Bounded wait for a level of the output
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (fp_out !== v && n < 6000)
    begin
      cyc();
      n++;
    end
  endtask

  // Cycles the output holds a level, bounded
  task automatic count(input logic v, output int c);
    c = 0;
    while (fp_out === v && c < 6000)
    begin
      cyc();
      c++;
    end
  endtask

  // Restart with a new shape and measure the first pulse
  task automatic pulse(input logic [7:0] shape, output int w);
    logic act;
    act = ~shape[7];
    wr(8'h51, 8'h00);
    wr(8'h57, shape);
    repeat (2) cyc();
    check("out_stopped", fp_out, 1'b0);
    wr(8'h51, 8'h04);
    wait_lvl(~act);
    wait_lvl(act);
    check("sync_level", synth, !shape[1]);
    count(act, w);
    check("idle_level", fp_out, !act);
  endtask

  // Cycles from run enable to the first clock-style rise for a given offset
  task automatic delay(input logic [7:0] lo, input logic [7:0] md, input logic [7:0] hi, output int c);
    wr(8'h51, 8'h00);
    wr(8'h58, lo);
    wr(8'h59, md);
    wr(8'h5a, hi);
    wr(8'h51, 8'h04);
    c = 0;
    while (fp_out !== 1'b1 && c < 3000)
    begin
      cyc();
      c++;
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    cyc();
    check("out_reset", fp_out, 1'b0);
    for (int k = 0; k < 6; k++)
    begin
      rd(8'h51 + k[7:0] + ((k > 0) ? 8'h04 : 8'h00), rv);
      check("reg_reset", rv, (k == 0) ? 8'h04 : (k == 1) ? 8'h05 : (k == 2) ? 8'h23 : 8'h00);
    end
    for (int k = 0; k < 6; k++)
    begin
      wr(ta[k], tw[k]);
      rd(ta[k], rv);
      check("reg_rw", rv, te[k]);
    end
    cyc();
    check("rdata_idle", reg_rdata, 8'h00);
    wr(8'h58, 8'h00);
    wr(8'h59, 8'h00);
    wr(8'h5a, 8'h00);
    wr(8'h57, 8'h00);
    // Clock style at every rate: half period high, rest low
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h51, 8'h00);
      wr(8'h56, k[7:0]);
      wr(8'h51, 8'h04);
      wait_lvl(1'b1);
      count(1'b1, h);
      count(1'b0, l);
      check("high_time", h, per[k] / 2);
      check("low_time", l, per[k] - per[k] / 2);
    end
    // Pulse style, widths 0 to 5 alternating sync edge
    wr(8'h56, 8'h07);
    for (int k = 0; k < 6; k++)
    begin
      pulse({1'b0, k[2:0], 2'b00, k[0], 1'b1}, d);
      check("width", d, 1);
    end
    pulse(8'h73, d);
    check("width_clk0", d, 16);
    pulse(8'h81, d);
    check("width_neg", d, 1);
    // Offsets measured in clock style at period 100
    wr(8'h56, 8'h02);
    wr(8'h57, 8'h00);
    delay(8'h00, 8'h00, 8'h00, base);
    delay(8'h07, 8'h02, 8'h00, d);
    check("fine_648", d - base, 25);
    @(posedge clock);
    sonet <= 1'b1;
    delay(8'h07, 8'h02, 8'h00, d);
    check("fine_1944", d - base, 16);
    delay(8'h00, 8'h00, 8'h01, d);
    check("coarse", d - base, 50);
    delay(8'h07, 8'h02, 8'h01, d);
    check("offset_22", d - base, 66);
    complete_run();
  end

  // Watchdog at 50k cycles, several times the expected run length
  initial
  begin
    #5_000_000;
    error_cnt++;
    complete_run();
  end
endmodule
